// ==== spou_pkg.sv ====
/*
 Constants and carrier types for the second serial port.
 Assumes one system clock; the peripheral clock is that clock gated by idle.
*/
package spou_pkg;
    // Special-function addresses
    localparam logic [7:0] SFR_CONTROL = 8'hc0;
    localparam logic [7:0] SFR_DATA = 8'hc1;
    // Control register field positions
    localparam int MODE_HI_POS = 7;
    localparam int MODE_MID_POS = 6;
    localparam int MODE_THIRD_POS = 5;
    localparam int RX_ENABLE_POS = 4;
    localparam int TX_NINTH_POS = 3;
    localparam int RX_NINTH_POS = 2;
    localparam int TX_DONE_POS = 1;
    localparam int RX_DONE_POS = 0;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Mode 0 bit periods in peripheral clocks
    localparam logic [3:0] M0_PERIOD_SLOW = 4'hc;
    localparam logic [3:0] M0_PERIOD_FAST = 4'h4;
    // Mode 2 bit periods in peripheral clocks
    localparam int M2_PERIOD = 64;
    localparam int M2_PERIOD_DBL = 32;
    // Oversample ticks per asynchronous bit
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] OS_MID = 4'(OVERSAMPLE / 2 - 1);
    // Peripheral clocks per oversample tick in mode 2
    localparam logic [2:0] M2_TICK_DIV = 3'(M2_PERIOD / OVERSAMPLE);
    localparam logic [2:0] M2_TICK_DIV_DBL = 3'(M2_PERIOD_DBL / OVERSAMPLE);
    // Frame lengths in bits and last bit indices
    localparam logic [3:0] FRAME_SHORT = 4'ha;
    localparam logic [3:0] FRAME_LONG = 4'hb;
    localparam logic [3:0] RX_LAST_IDX = 4'h9;
    localparam logic [3:0] M0_LAST_IDX = 4'h7;
    // Operating modes
    typedef enum logic [1:0] {
        SPOU_MODE0 = 2'b00,
        SPOU_MODE1 = 2'b01,
        SPOU_MODE2 = 2'b10,
        SPOU_MODE3 = 2'b11
    } spou_mode_t;
    // Special-function access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spou_sfr_req_t;
endpackage

// ==== spou_serial_port.sv ====
/*
 Transmit FIFO and the second serial port with its special-function registers.
 Assumes the core drives spou_sfr_req_t on sys_clk and that Timer 1 overflow
 arrives as a one-cycle pulse on the same clock.
*/

// Small FIFO with valid and ready on both sides
module spou_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH]; // Storage words
    logic [AW-1:0] wr_ptr_r; // Next slot to fill
    logic [AW-1:0] rd_ptr_r; // Oldest word
    logic [CW-1:0] count_r; // Words held
    logic push; // Word accepted
    logic pop; // Word drained

    assign in_ready = (count_r != CW'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage write, no reset needed on data
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers wrap at depth; fill count goes up on push, down on pop
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// Serial port core with control and data buffer registers
module spou_serial_port #(
    parameter int TX_DEPTH = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Special-function access
    input wire spou_pkg::spou_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // Neighbouring chip state
    input wire logic idle_mode,
    input wire logic timer1_overflow,
    input wire logic port1_rate_doubling_bit,
    input wire logic intr_enable,
    // Interrupt and back-pressure
    output logic irq,
    output logic tx_space,
    // Serial pins
    output logic txd,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe
);
    import spou_pkg::*;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ASYNC = 2'b01,
        TX_SYNC = 2'b10
    } spou_tx_state_t;
    typedef enum logic {
        RX_IDLE = 1'b0,
        RX_BUSY = 1'b1
    } spou_rx_state_t;

    // Mode 0 bit period from the third mode bit
    function automatic logic [3:0] m0_period(input logic third);
        m0_period = third ? M0_PERIOD_FAST : M0_PERIOD_SLOW;
    endfunction

    logic [7:0] ctrl_r; // Control register
    logic [7:0] rx_buf_r; // Receive buffer
    logic [2:0] rx_sync_r; // Pin synchroniser
    logic rx_level_r; // Filtered line level
    logic half_r; // Timer 1 overflow halver
    logic [2:0] m2_cnt_r; // Mode 2 tick divider
    spou_tx_state_t tx_state_r; // Shift engine state
    logic [10:0] shift_r; // Outgoing frame or mode 0 input
    logic [3:0] os_cnt_r; // Transmit oversample phase
    logic [3:0] bit_idx_r; // Transmit bit index
    logic [3:0] len_r; // Transmit frame length
    logic [3:0] m0_cnt_r; // Mode 0 period phase
    logic m0_rx_r; // Mode 0 transfer is a receive
    spou_rx_state_t rx_state_r; // Receiver state
    logic [3:0] rx_os_r; // Receive oversample phase
    logic [3:0] rx_idx_r; // Receive bit index
    logic [7:0] rx_shift_r; // Receive shifter
    logic txd_r, rxd_out_r, rxd_oe_r, irq_r, tx_space_r; // Output flops
    logic [7:0] rdata_r; // Read data flop

    spou_mode_t mode; // Selected mode
    logic third; // Third mode bit
    logic pclk_en; // Peripheral clock running
    logic os_tick; // Oversample tick
    logic [2:0] m2_div; // Mode 2 divider length
    logic wr_ctrl, wr_data; // Register writes
    logic fifo_valid; // Transmit byte waiting
    logic fifo_ready; // Transmit FIFO has room
    logic [7:0] fifo_data; // Next byte to send
    logic tx_go; // Start a transmit frame
    logic rx0_go; // Start a mode 0 receive
    logic async_bit_end, sync_bit_end, sync_done; // Shift engine events
    logic ti_set; // Transmit-done event
    logic rx_sample; // Receive sample point
    logic rx_frame_end; // Last receive sample
    logic rx_accept; // Receive byte taken
    logic ri_set; // Receive-done event
    logic [3:0] m0_per; // Current mode 0 period

    assign mode = spou_mode_t'({ctrl_r[MODE_HI_POS], ctrl_r[MODE_MID_POS]});
    assign third = ctrl_r[MODE_THIRD_POS];
    assign pclk_en = !idle_mode;
    assign m0_per = m0_period(third);
    assign wr_ctrl = sfr_req.wr && (sfr_req.addr == SFR_CONTROL);
    assign wr_data = sfr_req.wr && (sfr_req.addr == SFR_DATA);
    assign m2_div = port1_rate_doubling_bit ? M2_TICK_DIV_DBL : M2_TICK_DIV;

    // Oversample tick from Timer 1 or the fixed mode 2 divider
    always_comb begin
        if (mode == SPOU_MODE2) begin
            os_tick = pclk_en && (m2_cnt_r == m2_div - 3'h1);
        end else begin
            os_tick = pclk_en && timer1_overflow
                && (port1_rate_doubling_bit || half_r);
        end
    end

    // Transmit and mode 0 receive start conditions; the done flag must be clear first
    assign tx_go = pclk_en && (tx_state_r == TX_IDLE) && fifo_valid
        && !ctrl_r[TX_DONE_POS];
    assign rx0_go = pclk_en && (tx_state_r == TX_IDLE) && !tx_go
        && (mode == SPOU_MODE0) && ctrl_r[RX_ENABLE_POS]
        && !ctrl_r[RX_DONE_POS];
    assign async_bit_end = (tx_state_r == TX_ASYNC) && os_tick
        && (os_cnt_r == OS_LAST);
    assign sync_bit_end = pclk_en && (tx_state_r == TX_SYNC)
        && (m0_cnt_r == m0_per - 4'h1);
    assign sync_done = sync_bit_end && (bit_idx_r == M0_LAST_IDX);
    assign ti_set = (async_bit_end && (bit_idx_r == len_r - 4'h2))
        || (sync_done && !m0_rx_r);
    assign rx_sample = (rx_state_r == RX_BUSY) && os_tick
        && (rx_os_r == OS_MID);
    assign rx_frame_end = rx_sample && (rx_idx_r == RX_LAST_IDX);
    assign rx_accept = rx_frame_end && !ctrl_r[RX_DONE_POS]
        && (!third || rx_level_r);
    assign ri_set = rx_accept || (sync_done && m0_rx_r);

    // Transmit bytes queue here until the engine takes them
    spou_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(wr_data),
        .in_ready(fifo_ready),
        .in_data(sfr_req.wdata),
        .out_valid(fifo_valid),
        .out_ready(tx_go),
        .out_data(fifo_data)
    );

    // Three-stage pin synchroniser with agreement filter
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sync_r <= 3'h7;
            rx_level_r <= 1'b1;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], rxd_in};
            if (rx_sync_r[1] == rx_sync_r[2]) begin
                rx_level_r <= rx_sync_r[2];
            end
        end
    end

    // Bit-rate prescalers, frozen in idle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            half_r <= 1'b0;
            m2_cnt_r <= 3'h0;
        end else if (pclk_en) begin
            if (timer1_overflow) begin
                half_r <= !half_r;
            end
            m2_cnt_r <= (m2_cnt_r >= m2_div - 3'h1) ? 3'h0 : m2_cnt_r + 3'h1;
        end
    end

    // Shift engine: async transmit and mode 0 in both directions
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_r <= TX_IDLE;
            shift_r <= 11'h7ff;
            os_cnt_r <= 4'h0;
            bit_idx_r <= 4'h0;
            len_r <= FRAME_SHORT;
            m0_cnt_r <= 4'h0;
            m0_rx_r <= 1'b0;
        end else if (pclk_en) begin
            case (tx_state_r)
                TX_IDLE: begin
                    os_cnt_r <= 4'h0;
                    bit_idx_r <= 4'h0;
                    m0_cnt_r <= 4'h0;
                    if (tx_go && mode == SPOU_MODE0) begin
                        tx_state_r <= TX_SYNC;
                        shift_r <= {3'h7, fifo_data};
                        m0_rx_r <= 1'b0;
                    end else if (tx_go && mode == SPOU_MODE1) begin
                        tx_state_r <= TX_ASYNC;
                        shift_r <= {2'h3, fifo_data, 1'b0};
                        len_r <= FRAME_SHORT;
                    end else if (tx_go) begin
                        tx_state_r <= TX_ASYNC;
                        shift_r <= {1'b1, ctrl_r[TX_NINTH_POS], fifo_data,
                            1'b0};
                        len_r <= FRAME_LONG;
                    end else if (rx0_go) begin
                        tx_state_r <= TX_SYNC;
                        shift_r <= 11'h7ff;
                        m0_rx_r <= 1'b1;
                    end
                end
                TX_ASYNC: begin
                    if (os_tick) begin
                        os_cnt_r <= os_cnt_r + 4'h1;
                    end
                    if (async_bit_end) begin
                        shift_r <= {1'b1, shift_r[10:1]};
                        bit_idx_r <= bit_idx_r + 4'h1;
                        if (bit_idx_r == len_r - 4'h1) begin
                            tx_state_r <= TX_IDLE;
                        end
                    end
                end
                TX_SYNC: begin
                    m0_cnt_r <= sync_bit_end ? 4'h0 : m0_cnt_r + 4'h1;
                    if (sync_bit_end) begin
                        bit_idx_r <= bit_idx_r + 4'h1;
                        if (m0_rx_r) begin
                            shift_r <= {3'h7, rx_level_r, shift_r[7:1]};
                        end else begin
                            shift_r <= {1'b1, shift_r[10:1]};
                        end
                        if (sync_done) begin
                            tx_state_r <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    // Asynchronous receiver, sampling mid-bit
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_r <= RX_IDLE;
            rx_os_r <= 4'h0;
            rx_idx_r <= 4'h0;
            rx_shift_r <= 8'h00;
        end else if (pclk_en) begin
            case (rx_state_r)
                RX_IDLE: begin
                    rx_os_r <= 4'h0;
                    rx_idx_r <= 4'h0;
                    if (ctrl_r[RX_ENABLE_POS] && mode != SPOU_MODE0
                        && !rx_level_r) begin
                        rx_state_r <= RX_BUSY;
                    end
                end
                RX_BUSY: begin
                    if (os_tick) begin
                        rx_os_r <= rx_os_r + 4'h1;
                    end
                    if (!ctrl_r[RX_ENABLE_POS] || mode == SPOU_MODE0) begin
                        rx_state_r <= RX_IDLE;
                    end else if (rx_sample) begin
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (rx_idx_r == 4'h0 && rx_level_r) begin
                            rx_state_r <= RX_IDLE; // False start
                        end else if (rx_frame_end) begin
                            rx_state_r <= RX_IDLE;
                        end else if (rx_idx_r != 4'h0) begin
                            rx_shift_r <= {rx_level_r, rx_shift_r[7:1]};
                        end
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // Control register; hardware set beats a software clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= CONTROL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r[7:2] <= sfr_req.wdata[7:2];
            end
            if (rx_accept) begin
                ctrl_r[RX_NINTH_POS] <= rx_level_r;
            end
            ctrl_r[TX_DONE_POS] <= ti_set
                || (wr_ctrl ? sfr_req.wdata[TX_DONE_POS]
                : ctrl_r[TX_DONE_POS]);
            ctrl_r[RX_DONE_POS] <= ri_set
                || (wr_ctrl ? sfr_req.wdata[RX_DONE_POS]
                : ctrl_r[RX_DONE_POS]);
        end
    end

    // Receive buffer loads on an accepted byte or at the end of a mode 0 receive
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_buf_r <= DATA_RESET;
        end else if (rx_accept) begin
            rx_buf_r <= rx_shift_r;
        end else if (sync_done && m0_rx_r) begin
            rx_buf_r <= {rx_level_r, shift_r[7:1]};
        end
    end

    // Read data; unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else if (sfr_req.rd && sfr_req.addr == SFR_CONTROL) begin
            rdata_r <= ctrl_r;
        end else if (sfr_req.rd && sfr_req.addr == SFR_DATA) begin
            rdata_r <= rx_buf_r;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // Pins, interrupt and back-pressure from flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txd_r <= 1'b1;
            rxd_out_r <= 1'b1;
            rxd_oe_r <= 1'b0;
            irq_r <= 1'b0;
            tx_space_r <= 1'b0;
        end else begin
            irq_r <= intr_enable
                && (ctrl_r[TX_DONE_POS] || ctrl_r[RX_DONE_POS]);
            tx_space_r <= fifo_ready;
            case (tx_state_r)
                TX_ASYNC: txd_r <= shift_r[0];
                TX_SYNC: txd_r <= (m0_cnt_r >= (m0_per >> 1));
                default: txd_r <= 1'b1;
            endcase
            rxd_oe_r <= (tx_state_r == TX_SYNC) && !m0_rx_r;
            rxd_out_r <= (tx_state_r == TX_SYNC) ? shift_r[0] : 1'b1;
        end
    end

    assign sfr_rdata = rdata_r;
    assign irq = irq_r;
    assign tx_space = tx_space_r;
    assign txd = txd_r;
    assign rxd_out = rxd_out_r;
    assign rxd_oe = rxd_oe_r;
endmodule

// ==== spou_serial_port_assertions.sv ====
/*
 Checker for the second serial port, bound to spou_serial_port.
 Assumes it sees only the top ports, all on sys_clk with reset_n.
*/
module spou_serial_port_assertions
    import spou_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register access
    input wire spou_pkg::spou_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    // Chip state
    input wire logic idle_mode,
    input wire logic intr_enable,
    // Watched outputs
    input wire logic irq,
    input wire logic txd,
    input wire logic rxd_out,
    input wire logic rxd_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic [2:0] mode_r; // Mode field last written

    // Follow the mode field from control writes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= 3'h0;
        end else if (sfr_req.wr && sfr_req.addr == SFR_CONTROL) begin
            mode_r <= sfr_req.wdata[7:5];
        end
    end

    // Control read with no write in the same cycle
    sequence ctl_rd_s;
        sfr_req.rd && sfr_req.addr == SFR_CONTROL && !sfr_req.wr;
    endsequence
    // Control write, a quiet cycle, then a control read
    sequence ctl_wr_rd_s;
        sfr_req.wr && sfr_req.addr == SFR_CONTROL ##1 !sfr_req.wr ##1 ctl_rd_s;
    endsequence
    // Core quiet and clock stopped for three cycles
    sequence idle3_s;
        (idle_mode && !sfr_req.wr) [*3];
    endsequence

    rdata_idle_a: assert property (
        !$past(sfr_req.rd) |-> sfr_rdata == 8'h00)
        else $error("read data seen without a read");
    unmapped_read_a: assert property (
        sfr_req.rd && sfr_req.addr != SFR_CONTROL && sfr_req.addr != SFR_DATA
        |=> sfr_rdata == 8'h00)
        else $error("unmapped read returned data");
    irq_mask_a: assert property (
        !$past(intr_enable) |-> !irq)
        else $error("interrupt raised while disabled");
    irq_flags_a: assert property (
        (ctl_rd_s and intr_enable) |=> irq == (sfr_rdata[1:0] != 2'b00))
        else $error("interrupt does not follow the flags");
    ctl_write_a: assert property (
        ctl_wr_rd_s |=> sfr_rdata[7:3] == $past(sfr_req.wdata[7:3], 3))
        else $error("control field not kept");
    idle_freeze_a: assert property (
        idle3_s |-> $stable(txd) && $stable(rxd_out))
        else $error("serial pins moved in idle");
    shift_slow_a: assert property (
        mode_r == 3'b000 && $fell(txd) |-> !txd [*6] ##1 txd)
        else $error("slow shift clock low time wrong");
    shift_fast_a: assert property (
        mode_r == 3'b001 && $fell(txd) |-> !txd [*2] ##1 txd)
        else $error("fast shift clock low time wrong");
    shift_data_a: assert property (
        rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> $fell(txd))
        else $error("shift data changed off the clock fall");
endmodule

// ==== spou_remote_device.sv ====
/*
 Remote serial device on the line of the second serial port.
 Assumes the bench hands it the bit time in ns for each frame.
*/
module spou_remote_device (
    // Line from the port
    input wire logic txd,
    // Line to the port
    output logic rxd_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // Line rests high between frames
    initial rxd_in = 1'b1;

    // Send n bits LSB first; start and stop come in the bits
    task automatic send(input logic [10:0] bits, input int n, input real per);
        for (int i = 0; i < n; i++) begin
            rxd_in = bits[i];
            #(per);
        end
        rxd_in = 1'b1;
    endtask

    // Catch a frame from the start fall, sampling mid-bit
    task automatic recv(output logic [10:0] bits, input int n, input real per);
        bits = '0;
        @(negedge txd);
        #(per / 2.0);
        for (int i = 0; i < n; i++) begin
            bits[i] = txd;
            if (i < n - 1) #(per);
        end
    endtask
endmodule

// ==== spou_serial_port_test.sv ====
/*
 Self-checking bench for the second serial port with a line partner.
 Assumes the package, the design and the partner are compiled first.
*/
module spou_serial_port_test import spou_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int TXD = 4; // Transmit FIFO depth
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic timer1_overflow = 1'b0;
    logic reset_n, idle_mode, dbl, intr_enable;
    logic irq, tx_space, txd, rxd_in, rxd_out, rxd_oe;
    spou_sfr_req_t req;
    logic [7:0] sfr_rdata, q, d, got;
    logic [7:0] txq[$]; // Bytes expected on the line
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    time t0;
    int tm[4] = '{2, 2, 3, 1};
    int tn[4] = '{6, 1, 1, 1};
    int rm[6] = '{2, 2, 3, 1, 1, 1};
    logic [2:0] rv[6] = '{3'b011, 3'b101, 3'b111, 3'b001, 3'b100, 3'b000};

    spou_serial_port #(.TX_DEPTH(TXD)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .sfr_req(req),
        .sfr_rdata(sfr_rdata), .idle_mode(idle_mode),
        .timer1_overflow(timer1_overflow), .port1_rate_doubling_bit(dbl),
        .intr_enable(intr_enable), .irq(irq), .tx_space(tx_space),
        .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe));
    spou_remote_device peer (.txd(txd), .rxd_in(rxd_in));

    // System clock and unrelated bit-rate source
    always #5 sys_clk = ~sys_clk;
    always #62.5 link_clk = ~link_clk;
    // One-cycle overflow pulse per link clock rise
    always @(posedge link_clk) begin
        @(negedge sys_clk) timer1_overflow = 1'b1;
        @(negedge sys_clk) timer1_overflow = 1'b0;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_reg(string nm, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_frame(string nm, logic [10:0] e, logic [10:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One register access; read data taken one edge later
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] v, output logic [7:0] r);
        @(negedge sys_clk);
        req = '{wr: w, rd: !w, addr: a, wdata: v};
        @(negedge sys_clk);
        r = sfr_rdata;
        req = '0;
    endtask
    // Bit time in ns for the asynchronous modes
    function automatic real per(input int m);
        if (m == 2) return (dbl ? 32.0 : 64.0) * 10.0;
        return (dbl ? 16.0 : 32.0) * 125.0;
    endfunction
    // Expected frame, start bit at index 0
    function automatic logic [10:0] frame(logic [7:0] v, logic nb, int n);
        return (n == 10) ? {2'b01, v, 1'b0} : {1'b1, nb, v, 1'b0};
    endfunction

    // Write n bytes and follow out on the line those not dropped when the FIFO is full
    task automatic tx_run(input int m, input int n);
        logic nb;
        int nbits;
        logic [10:0] f;
        logic [7:0] c, r;
        nb = 1'($urandom);
        nbits = (m == 1) ? 10 : 11;
        c = {m[1], m[0], 2'b00, nb, 3'b000};
        acc(1'b1, SFR_CONTROL, c, r);
        fork
            begin
                for (int i = 0; i < n; i++) begin
                    d = 8'($urandom);
                    if (i <= TXD) txq.push_back(d);
                    acc(1'b1, SFR_DATA, d, q);
                end
                if (n > TXD) chk_reg("tx space", 8'h00, 8'(tx_space));
            end
            for (int i = 0; i < ((n > TXD) ? TXD + 1 : n); i++) begin
                peer.recv(f, nbits, per(m));
                chk_frame("tx frame", frame(txq.pop_front(), nb, nbits), f);
                acc(1'b0, SFR_CONTROL, 8'h00, r);
                chk_reg("tx control", c | 8'h02, r);
                acc(1'b1, SFR_CONTROL, c, r);
            end
        join
        chk_reg("tx drained", 8'h01, 8'(tx_space));
    endtask

    // Send one frame in; v is third bit, ninth bit, stop bit
    task automatic rx_run(input int m, input logic [2:0] v);
        logic [7:0] c, r;
        logic hit, b9;
        b9 = (m == 1) ? v[0] : v[1];
        hit = !v[2] || b9;
        d = 8'($urandom);
        c = {m[1], m[0], v[2], 1'b1, 4'h0};
        acc(1'b1, SFR_CONTROL, c, r);
        peer.send((m == 1) ? {1'b0, v[0], d, 1'b0} : {v[0], v[1], d, 1'b0},
                  (m == 1) ? 10 : 11, per(m));
        acc(1'b0, SFR_CONTROL, 8'h00, r);
        chk_reg("rx control", c | {5'h0, hit & b9, 1'b0, hit}, r);
        acc(1'b0, SFR_DATA, 8'h00, r);
        if (hit) chk_reg("rx data", d, r);
        acc(1'b1, SFR_CONTROL, 8'h00, r);
    endtask

    // Main sequence
    initial begin
        req = '0;
        idle_mode = 1'b0;
        dbl = 1'b0;
        intr_enable = 1'b0;
        reset_n = 1'b0;
        q = 8'($urandom(32'h4559));
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        acc(1'b0, SFR_CONTROL, 8'h00, q);
        chk_reg("control reset", 8'h00, q);
        acc(1'b0, SFR_DATA, 8'h00, q);
        chk_reg("data reset", 8'h00, q);
        acc(1'b1, 8'hc2, 8'hff, q);
        acc(1'b0, 8'hc2, 8'h00, q);
        chk_reg("unmapped", 8'h00, q);
        // Each flag raises, masks and clears the interrupt
        for (int f = 1; f < 3; f++) begin
            intr_enable = 1'b1;
            acc(1'b1, SFR_CONTROL, 8'(f), q);
            acc(1'b0, SFR_CONTROL, 8'h00, q);
            chk_reg("flags", 8'(f), q);
            chk_reg("irq on", 8'h01, 8'(irq));
            intr_enable = 1'b0;
            repeat (2) @(negedge sys_clk);
            chk_reg("irq masked", 8'h00, 8'(irq));
            intr_enable = 1'b1;
            acc(1'b1, SFR_CONTROL, 8'h00, q);
            repeat (2) @(negedge sys_clk);
            chk_reg("irq cleared", 8'h00, 8'(irq));
        end
        for (int i = 0; i < 4; i++) begin
            dbl = 1'(i);
            tx_run(tm[i], tn[i]);
        end
        foreach (rm[i]) rx_run(rm[i], rv[i]);
        // Shift mode out at both speeds
        for (int s = 0; s < 2; s++) begin
            d = 8'($urandom);
            acc(1'b1, SFR_CONTROL, {2'b00, 1'(s), 5'h00}, q);
            fork
                acc(1'b1, SFR_DATA, d, q);
                for (int i = 0; i < 8; i++) begin
                    @(posedge txd);
                    #1;
                    got[i] = rxd_out;
                    if (i == 0) t0 = $time;
                    if (i == 1) chk_reg("shift period", s ? 8'h04 : 8'h0c,
                                        8'(($time - t0) / 10));
                end
            join
            chk_reg("shift data", d, got);
            repeat (12) @(negedge sys_clk);
            acc(1'b0, SFR_CONTROL, 8'h00, q);
            chk_reg("shift done", {2'b00, 1'(s), 5'h02}, q);
            acc(1'b1, SFR_CONTROL, 8'h00, q);
        end
        // Shift mode in from an idle-high line
        acc(1'b1, SFR_CONTROL, 8'h10, q);
        repeat (33) @(negedge sys_clk);
        idle_mode = 1'b1;
        repeat (200) @(negedge sys_clk);
        chk_reg("idle hold", 8'h00, 8'(irq));
        idle_mode = 1'b0;
        repeat (120) @(negedge sys_clk);
        acc(1'b0, SFR_CONTROL, 8'h00, q);
        chk_reg("shift rx control", 8'h11, q);
        acc(1'b0, SFR_DATA, 8'h00, q);
        chk_reg("shift rx data", 8'hff, q);
        summarize();
    end
endmodule

bind spou_serial_port spou_serial_port_assertions chk (
    .sys_clk, .reset_n, .sfr_req, .sfr_rdata, .idle_mode, .intr_enable,
    .irq, .txd, .rxd_out, .rxd_oe);
